// file: rom_bus_model.sv
// Behavioural DC bus that feeds the monitor its voltage sample.
// Assumes the bench commands braking and the bus level for it.
`timescale 1ns/100ps
`default_nettype none
module rom_bus_model #(
  parameter logic [15:0] IDLE_V = 16'h136
) (
  // Clock
  input wire logic clk,
  // Braking request from the bench
  input wire logic brake,
  input wire logic [15:0] level,
  // Sampled bus voltage in volts
  output var logic [15:0] volts
);
  initial volts = IDLE_V;
  // The bus only moves on a clock edge, as a sampled converter would.
  always @(posedge clk) begin
    volts <= brake ? level : IDLE_V;
  end
endmodule
`default_nettype wire

// file: rom_defs.vh
// Constants for the regenerative overload monitor: register indices,
// reset values, field positions and timing counts.
// Assumes a 16-bit register port and a 20 MHz core clock.
`ifndef ROM_DEFS_VH
`define ROM_DEFS_VH

// Register indices, used directly as port addresses.
`define ROM_ADDR_CONFIG 16'h2009
`define ROM_ADDR_DERATE 16'h200a
`define ROM_ADDR_RES 16'h200b
`define ROM_ADDR_POWER 16'h200c
`define ROM_ADDR_PEAK 16'h200d
`define ROM_ADDR_DUR 16'h200e
`define ROM_ADDR_IRQ_STAT 16'h2020
`define ROM_ADDR_IRQ_MASK 16'h2021
`define ROM_ADDR_CTRL 16'h2022
`define ROM_ADDR_RATE_LO 16'h2023
`define ROM_ADDR_RATE_HI 16'h2024
`define ROM_ADDR_STATE 16'h2025

// Reset values.
`define ROM_RST_CONFIG 16'h0001
`define ROM_RST_DERATE 16'h0064
`define ROM_RST_RES 16'h0000
`define ROM_RST_POWER 16'h0000
`define ROM_RST_PEAK 16'h0000
`define ROM_RST_DUR 16'h0000

// Resistor configuration value that selects the external resistor.
`define ROM_CFG_EXTERNAL 16'h0001

// Interrupt status and mask bit positions.
`define ROM_IRQ_ALARM 0
`define ROM_IRQ_START 1
`define ROM_IRQ_STOP 2
`define ROM_IRQ_BITS 3

// Control register bit: write one to clear the latched alarm.
`define ROM_CTRL_ALARM_CLR 0

// Bus voltage at which regeneration is active, and its square.
`define ROM_REGEN_VOLTS 16'h0181
`define ROM_REGEN_VOLTS_SQ 18'h24301

// Energy is summed once per millisecond.
`define ROM_CLK_NS 50
`define ROM_TICK_NS 1000000
`define ROM_TICK_CYCLES (`ROM_TICK_NS / `ROM_CLK_NS)

`endif

// file: rom_div.v
// Serial restoring divider that turns the programmed resistance into
// a consumption rate. One quotient bit is produced per clock.
// Assumes start is a one-cycle pulse; a start while busy restarts it.
`timescale 1ns/100ps
`default_nettype none
module rom_div #(
  parameter NW = 18,
  parameter DW = 16
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Request
  input wire start,
  input wire [NW-1:0] dividend,
  input wire [DW-1:0] divisor,
  // Result
  output reg busy,
  output reg done,
  output reg [NW-1:0] quotient
);
  reg [NW-1:0] num_q;
  reg [DW:0] rem_q;
  reg [DW-1:0] den_q;
  reg [5:0] cnt_q;
  wire [DW:0] rem_sh = {rem_q[DW-1:0], num_q[NW-1]};
  wire [DW:0] diff = rem_sh - {1'b0, den_q};

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
      done <= 1'b0;
      quotient <= {NW{1'b1}};
      num_q <= {NW{1'b0}};
      rem_q <= {(DW+1){1'b0}};
      den_q <= {DW{1'b0}};
      cnt_q <= 6'h00;
    end else begin
      done <= 1'b0;
      if (start) begin
        num_q <= dividend;
        den_q <= divisor;
        rem_q <= {(DW+1){1'b0}};
        cnt_q <= NW[5:0];
        busy <= 1'b1;
      end else if (busy) begin
        num_q <= {num_q[NW-2:0], ~diff[DW]};
        rem_q <= diff[DW] ? rem_sh : diff;
        cnt_q <= cnt_q - 6'h01;
        if (cnt_q == 6'h01) begin
          busy <= 1'b0;
          done <= 1'b1;
          // A zero resistance gives the largest rate so the limit trips.
          quotient <= (den_q == {DW{1'b0}}) ? {NW{1'b1}} :
            {num_q[NW-2:0], ~diff[DW]};
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: rom_monitor.v
// Regenerative overload monitor: holds the braking resistor settings,
// derives the consumption rate and energy limit, integrates energy
// while the DC bus is regenerating and raises the overload alarm.
// Assumes a synchronous bus voltage sample and a single-cycle register
// port whose read data is consumed in the cycle after the strobe.
`timescale 1ns/100ps
`default_nettype none
`include "rom_defs.vh"

// Notes on behaviour
// - Configuration value one selects the external resistor; resets to one.
// - Resistance in ohms resets to zero; the operator must set it.
// - Continuous power in watts resets to zero; operator writes it too.
// - Regeneration is active at 385 V; rate is 385 squared over resistance.
// - Energy limit is peak power times derating times 0.01 times duration.
// - Alarm rises when accumulated regenerative energy exceeds the limit.
// - Regeneration longer than limit over rate raises the alarm.
// - A smaller derating value lowers the limit so the alarm comes sooner.
module rom_monitor #(
  parameter TICK_CYCLES = `ROM_TICK_CYCLES
) (
  // Clock and reset
  input wire CORE_CLK,
  input wire NRST,
  // Register port
  input wire [15:0] ADDR,
  input wire [15:0] WDATA,
  input wire WR,
  input wire RD,
  output reg [15:0] RDATA,
  // DC bus voltage sample in volts
  input wire [15:0] DC_BUS_VOLTS,
  // Status outputs
  output reg REGEN_ACTIVE,
  output reg REGEN_OVERLOAD_ALARM,
  output reg IRQ
);
  function hit;
    input [15:0] a;
    input [15:0] off;
    begin
      hit = (a == off);
    end
  endfunction

  // Software-visible settings.
  reg [15:0] config_q;
  reg [15:0] derate_q;
  reg [15:0] res_q;
  reg [15:0] power_q;
  reg [15:0] peak_q;
  reg [15:0] dur_q;
  reg [`ROM_IRQ_BITS-1:0] stat_q;
  reg [`ROM_IRQ_BITS-1:0] stat_d;
  reg [`ROM_IRQ_BITS-1:0] mask_q;

  // Integrator state.
  reg [17:0] rate_q;
  reg [41:0] acc_q;
  reg [41:0] acc_d;
  reg active_d;
  reg alarm_d;
  reg div_start_q;
  reg [15:0] rdata_d;

  wire wr_res = WR && hit(ADDR, `ROM_ADDR_RES);
  wire wr_ctrl = WR && hit(ADDR, `ROM_ADDR_CTRL);
  wire alarm_clr = wr_ctrl && WDATA[`ROM_CTRL_ALARM_CLR];
  wire external = (config_q == `ROM_CFG_EXTERNAL);
  wire div_busy;
  wire div_done;
  wire [17:0] div_q;
  wire tick;

  // The tick restarts whenever regeneration is not under way, so every
  // summed millisecond lies inside one continuous burst.
  rom_tick #(
    .N(TICK_CYCLES)
  ) u_tick (
    .clk(CORE_CLK),
    .rst_n(NRST),
    .clr(!REGEN_ACTIVE),
    .tick(tick)
  );

  // Rate recompute is launched the cycle after a resistance write and
  // once after reset; the old rate stays in use until it finishes.
  rom_div #(
    .NW(18),
    .DW(16)
  ) u_div (
    .clk(CORE_CLK),
    .rst_n(NRST),
    .start(div_start_q),
    .dividend(`ROM_REGEN_VOLTS_SQ),
    .divisor(res_q),
    .busy(div_busy),
    .done(div_done),
    .quotient(div_q)
  );

  // Limit in watt-milliseconds times one hundred; the 0.01 factor is
  // moved to the other side of the comparison to avoid a division.
  wire [47:0] limit_x100 = peak_q * derate_q * dur_q;
  wire [48:0] acc_x100 = {1'b0, acc_q, 6'h00} +
    {2'h0, acc_q, 5'h00} + {5'h00, acc_q, 2'h0};
  wire over = acc_x100 > {1'b0, limit_x100};
  wire [42:0] acc_sum = {1'b0, acc_q} + {25'h0000000, rate_q};

  // Settings registers.
  always @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      config_q <= `ROM_RST_CONFIG;
      derate_q <= `ROM_RST_DERATE;
      res_q <= `ROM_RST_RES;
      power_q <= `ROM_RST_POWER;
      peak_q <= `ROM_RST_PEAK;
      dur_q <= `ROM_RST_DUR;
      mask_q <= {`ROM_IRQ_BITS{1'b0}};
    end else if (WR) begin
      if (hit(ADDR, `ROM_ADDR_CONFIG)) begin
        config_q <= WDATA;
      end
      if (hit(ADDR, `ROM_ADDR_DERATE)) begin
        derate_q <= WDATA;
      end
      if (hit(ADDR, `ROM_ADDR_RES)) begin
        res_q <= WDATA;
      end
      if (hit(ADDR, `ROM_ADDR_POWER)) begin
        power_q <= WDATA;
      end
      if (hit(ADDR, `ROM_ADDR_PEAK)) begin
        peak_q <= WDATA;
      end
      if (hit(ADDR, `ROM_ADDR_DUR)) begin
        dur_q <= WDATA;
      end
      if (hit(ADDR, `ROM_ADDR_IRQ_MASK)) begin
        mask_q <= WDATA[`ROM_IRQ_BITS-1:0];
      end
    end
  end

  // Consumption rate, held until a new one is ready.
  always @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      div_start_q <= 1'b1;
      rate_q <= {18{1'b1}};
    end else begin
      div_start_q <= wr_res;
      if (div_done) begin
        rate_q <= div_q;
      end
    end
  end

  // Regeneration detection, integration and alarm.
  always @* begin
    active_d = external && (DC_BUS_VOLTS >= `ROM_REGEN_VOLTS);
    acc_d = acc_q;
    if (!REGEN_ACTIVE) begin
      acc_d = 42'h00000000000;
    end else if (tick) begin
      acc_d = acc_sum[42] ? {42{1'b1}} : acc_sum[41:0];
    end
    alarm_d = REGEN_OVERLOAD_ALARM;
    if (alarm_clr) begin
      alarm_d = 1'b0;
    end
    // A fresh overload in the clearing cycle keeps the alarm up.
    if (external && REGEN_ACTIVE && over) begin
      alarm_d = 1'b1;
    end
  end

  always @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      REGEN_ACTIVE <= 1'b0;
      REGEN_OVERLOAD_ALARM <= 1'b0;
      acc_q <= 42'h00000000000;
    end else begin
      REGEN_ACTIVE <= active_d;
      REGEN_OVERLOAD_ALARM <= alarm_d;
      acc_q <= acc_d;
    end
  end

  // Sticky interrupt status, cleared by reading it; new events win.
  always @* begin
    stat_d = stat_q;
    if (RD && hit(ADDR, `ROM_ADDR_IRQ_STAT)) begin
      stat_d = {`ROM_IRQ_BITS{1'b0}};
    end
    if (alarm_d && !REGEN_OVERLOAD_ALARM) begin
      stat_d[`ROM_IRQ_ALARM] = 1'b1;
    end
    if (active_d && !REGEN_ACTIVE) begin
      stat_d[`ROM_IRQ_START] = 1'b1;
    end
    if (!active_d && REGEN_ACTIVE) begin
      stat_d[`ROM_IRQ_STOP] = 1'b1;
    end
  end

  always @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      stat_q <= {`ROM_IRQ_BITS{1'b0}};
      IRQ <= 1'b0;
    end else begin
      stat_q <= stat_d;
      IRQ <= |(stat_d & mask_q);
    end
  end

  // Read data, presented in the cycle after the strobe only.
  always @* begin
    rdata_d = 16'h0000;
    case (ADDR)
      `ROM_ADDR_CONFIG: rdata_d = config_q;
      `ROM_ADDR_DERATE: rdata_d = derate_q;
      `ROM_ADDR_RES: rdata_d = res_q;
      `ROM_ADDR_POWER: rdata_d = power_q;
      `ROM_ADDR_PEAK: rdata_d = peak_q;
      `ROM_ADDR_DUR: rdata_d = dur_q;
      `ROM_ADDR_IRQ_STAT: rdata_d = {13'h0000, stat_q};
      `ROM_ADDR_IRQ_MASK: rdata_d = {13'h0000, mask_q};
      `ROM_ADDR_RATE_LO: rdata_d = rate_q[15:0];
      `ROM_ADDR_RATE_HI: rdata_d = {14'h0000, rate_q[17:16]};
      `ROM_ADDR_STATE: rdata_d = {12'h000, over, div_busy,
        REGEN_OVERLOAD_ALARM, REGEN_ACTIVE};
      default: rdata_d = 16'h0000;
    endcase
  end

  always @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      RDATA <= 16'h0000;
    end else begin
      RDATA <= RD ? rdata_d : 16'h0000;
    end
  end
endmodule
`default_nettype wire

// file: rom_monitor_asserts.sv
// Port checker for the regenerative overload monitor.
// Assumes the monitor register map and one-cycle read data.
`timescale 1ns/100ps
`default_nettype none
module rom_monitor_asserts (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic NRST,
  // Register port
  input wire logic [15:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [15:0] RDATA,
  // Bus and status
  input wire logic [15:0] DC_BUS_VOLTS,
  input wire logic REGEN_ACTIVE,
  input wire logic REGEN_OVERLOAD_ALARM,
  input wire logic IRQ
);
  logic [15:0] cfg_q;
  logic [2:0] msk_q;
  wire logic clr = WR && ADDR == 16'h2022 && WDATA[0];
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!NRST);
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      cfg_q <= 16'h1;
      msk_q <= 3'h0;
    end else if (WR && ADDR == 16'h2009) begin
      cfg_q <= WDATA;
    end else if (WR && ADDR == 16'h2021) begin
      msk_q <= WDATA[2:0];
    end
  end
  property p_act;
    REGEN_ACTIVE == $past(cfg_q == 16'h1 && DC_BUS_VOLTS >= 16'h181);
  endproperty
  a_act: assert property (p_act)
    else $error("active flag wrong");
  property p_cfg;
    $past(RD && ADDR == 16'h2009) |-> RDATA == $past(cfg_q);
  endproperty
  a_cfg: assert property (p_cfg)
    else $error("config read wrong");
  property p_hold;
    REGEN_OVERLOAD_ALARM && !clr |=> REGEN_OVERLOAD_ALARM;
  endproperty
  a_hold: assert property (p_hold)
    else $error("alarm dropped");
  property p_cause;
    $rose(REGEN_OVERLOAD_ALARM) |-> $past(cfg_q == 16'h1) &&
      ($past(REGEN_ACTIVE) || $past(REGEN_ACTIVE, 2) ||
      $past(REGEN_ACTIVE, 3));
  endproperty
  a_cause: assert property (p_cause)
    else $error("alarm without regeneration");
  property p_clr;
    clr && !REGEN_ACTIVE && !$past(REGEN_ACTIVE) &&
      !$past(REGEN_ACTIVE, 2) |=> !REGEN_OVERLOAD_ALARM;
  endproperty
  a_clr: assert property (p_clr)
    else $error("alarm not cleared");
  property p_irq_al;
    $rose(REGEN_OVERLOAD_ALARM) && msk_q[0] |-> ##[0:2] IRQ;
  endproperty
  a_irq_al: assert property (p_irq_al)
    else $error("no interrupt on alarm");
  property p_irq_on;
    $rose(REGEN_ACTIVE) && msk_q[1] |-> ##[0:2] IRQ;
  endproperty
  a_irq_on: assert property (p_irq_on)
    else $error("no interrupt on start");
  property p_irq_off;
    $fell(REGEN_ACTIVE) && msk_q[2] |-> ##[0:2] IRQ;
  endproperty
  a_irq_off: assert property (p_irq_off)
    else $error("no interrupt on stop");
endmodule
bind rom_monitor rom_monitor_asserts chk_u (.CORE_CLK(CORE_CLK),
  .NRST(NRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
  .RDATA(RDATA), .DC_BUS_VOLTS(DC_BUS_VOLTS), .REGEN_ACTIVE(REGEN_ACTIVE),
  .REGEN_OVERLOAD_ALARM(REGEN_OVERLOAD_ALARM), .IRQ(IRQ));
`default_nettype wire

// file: rom_monitor_tb.sv
// Self-checking bench for the regenerative overload monitor.
// Assumes the behavioural bus model and a shortened energy tick.
`timescale 1ns/100ps
`default_nettype none
`include "rom_defs.vh"
module rom_monitor_tb;
  localparam int TK = 10;
  logic clk = 1'h0, nrst = 1'h0, wr = 1'h0, rd = 1'h0, brake = 1'h0;
  logic [15:0] addr = 16'h0, wdata = 16'h0, lvl = 16'h0, lf = 16'hb1cd;
  wire [15:0] rdata, volts;
  wire act, alarm, irq;
  int miscompares = 0, num_checks = 0;
  // Mirrors the written resistor configuration for the expected activity.
  logic ext = 1'b1;
  rom_monitor #(.TICK_CYCLES(TK)) dut_u (.CORE_CLK(clk), .NRST(nrst),
    .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .DC_BUS_VOLTS(volts), .REGEN_ACTIVE(act),
    .REGEN_OVERLOAD_ALARM(alarm), .IRQ(irq));
  rom_bus_model bus_u (.clk(clk), .brake(brake), .level(lvl),
    .volts(volts));
  initial forever #25 clk = ~clk;
  function automatic logic [15:0] nx(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  function automatic int rate(input int r);
    return r == 0 ? 18'h3ffff : 18'h24301 / r;
  endfunction
  // The limit compare is strict, so one tick more than the quotient.
  function automatic int ticks(input int pk, d, du, r);
    return pk * d * du / (100 * rate(r)) + 1;
  endfunction
  task automatic chk(input logic [15:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [15:0] a, d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [15:0] a, exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  // Brakes until the alarm shows or k cycles pass; c counts the cycles.
  task automatic regen(input logic [15:0] l, input int k, output int c);
    @(posedge clk);
    lvl <= l;
    brake <= 1'b1;
    c = 0;
    do begin
      @(negedge clk);
      c++;
    end while (alarm !== 1'b1 && c < k);
    chk({15'h0, act}, {15'h0, ext && l >= 16'h181});
    @(posedge clk);
    brake <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task automatic finish_test;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    finish_test;
  end
  initial begin
    int r, pk, d, n, c;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    rd_chk(`ROM_ADDR_CONFIG, 16'h1);
    rd_chk(`ROM_ADDR_RES, 16'h0);
    rd_chk(`ROM_ADDR_POWER, 16'h0);
    rd_chk(`ROM_ADDR_DERATE, 16'h64);
    rd_chk(16'h2030, 16'h0);
    lf = nx(lf);
    wr_reg(`ROM_ADDR_POWER, lf);
    wr_reg(`ROM_ADDR_PEAK, lf * 16'h5);
    wr_reg(`ROM_ADDR_DUR, 16'h1388);
    rd_chk(`ROM_ADDR_POWER, lf);
    rd_chk(`ROM_ADDR_PEAK, lf * 16'h5);
    rd_chk(`ROM_ADDR_DUR, 16'h1388);
    r = 20 + lf[4:0];
    wr_reg(`ROM_ADDR_RES, 16'(r));
    wr_reg(`ROM_ADDR_IRQ_MASK, 16'h7);
    repeat (25) @(posedge clk);
    n = rate(r);
    rd_chk(`ROM_ADDR_RATE_LO, n[15:0]);
    rd_chk(`ROM_ADDR_RATE_HI, {14'h0, n[17:16]});
    regen(16'h180, 40, c);
    rd_chk(`ROM_ADDR_IRQ_STAT, 16'h0);
    for (int i = 0; i < 3; i++) begin
      d = i == 0 ? 100 : i == 1 ? 50 : 150;
      lf = nx(lf);
      pk = lf[9:0] + 1;
      wr_reg(`ROM_ADDR_DERATE, 16'(d));
      wr_reg(`ROM_ADDR_PEAK, 16'(pk));
      wr_reg(`ROM_ADDR_DUR, 16'h32);
      wr_reg(`ROM_ADDR_IRQ_MASK, i == 1 ? 16'h0 : 16'h7);
      n = ticks(pk, d, 50, r);
      regen(16'h181, n * TK - 5, c);
      rd_chk(`ROM_ADDR_IRQ_STAT, 16'h6);
      regen(16'h181, n * TK + 40, c);
      @(negedge clk);
      chk(16'(c / TK), 16'(n));
      chk({15'h0, irq}, {15'h0, i != 1});
      rd_chk(`ROM_ADDR_IRQ_STAT, 16'h7);
      chk({15'h0, irq}, 16'h0);
      wr_reg(`ROM_ADDR_CTRL, 16'h1);
      rd_chk(`ROM_ADDR_STATE, 16'h0);
    end
    wr_reg(`ROM_ADDR_CONFIG, 16'h0);
    ext = 1'b0;
    regen(16'h181, 100, c);
    chk(16'(c), 16'h64);
    rd_chk(`ROM_ADDR_IRQ_STAT, 16'h0);
    // A reset in mid-run must bring back the documented settings.
    @(posedge clk);
    nrst <= 1'b0;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    rd_chk(`ROM_ADDR_CONFIG, 16'h1);
    rd_chk(`ROM_ADDR_RES, 16'h0);
    repeat (25) @(posedge clk);
    rd_chk(`ROM_ADDR_RATE_HI, 16'h3);
    rd_chk(`ROM_ADDR_RATE_LO, 16'hffff);
    finish_test;
  end
endmodule
`default_nettype wire

// file: rom_tick.v
// Millisecond tick generator for the energy integrator.
// A clear restarts the period so the first tick of a regeneration
// burst comes one full period after it starts.
`timescale 1ns/100ps
`default_nettype none
module rom_tick #(
  parameter N = 20000
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Control and output
  input wire clr,
  output reg tick
);
  reg [31:0] cnt_q;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 32'h00000000;
      tick <= 1'b0;
    end else if (clr) begin
      cnt_q <= 32'h00000000;
      tick <= 1'b0;
    end else if (cnt_q == N - 1) begin
      cnt_q <= 32'h00000000;
      tick <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 32'h00000001;
      tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire
